// file: hdl/rbc_top.sv
`timescale 1ns/10ps
`default_nettype none
module rbc_top
   import rbc_pkg::*;
#(
   parameter int CFG_WIDTH = CFG_W
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic ext_reset_input,
   input wire logic nmi_in_n,
   input wire logic debug_reset_in,
   input wire logic external_access_select,
   input wire logic [CFG_WIDTH-1:0] low_config_port,
   input wire logic read_strobe_in,
   input wire logic addr_latch_strobe_in,
   input wire logic write_strobe_in,
   input wire logic sw_reset_req,
   input wire logic wdt_reset_req,
   input wire logic rstind_on_internal,
   input wire logic rstind_release_at_end,
   input wire logic end_of_init_instruction,
   input wire logic sw_rstind_release,
   input wire logic power_down_instruction,
   input wire logic wake_req,
   output logic cpu_reset,
   output logic reset_indication_output,
   output logic trap_req,
   output logic [15:0] trap_vector,
   output logic [6:0] trap_number,
   output logic debug_active,
   output logic fetch_external,
   output logic [CFG_WIDTH+2:0] boot_config,
   output logic clock_stop
);
   // ==========================================================
   // synchronisers
   logic [1:0] rst_sync_reg, nmi_sync_reg, dbg_sync_reg;
   logic [FILT_W-1:0] filt_cnt_reg;
   logic filt_reset_reg, nmi_prev_reg, filt_prev_reg;
   rbc_state_t state_reg;

   // first stage read only by second stage
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'b11;
         nmi_sync_reg <= 2'b11;
         dbg_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], ext_reset_input};
         nmi_sync_reg <= {nmi_sync_reg[0], nmi_in_n};
         dbg_sync_reg <= {dbg_sync_reg[0], debug_reset_in};
      end
   end

   // ==========================================================
   // spike filter: low must persist FILT_CYCLES clocks; glitch shorter than a clock unseen
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filt_cnt_reg <= '0;
         filt_reset_reg <= 1'b1;
      end else if (rst_sync_reg[1]) begin
         filt_cnt_reg <= '0;
         filt_reset_reg <= 1'b0; // release on a single high sample
      end else if (filt_cnt_reg == FILT_W'(FILT_CYCLES - 1)) begin
         filt_reset_reg <= 1'b1;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 1'b1;
      end
   end

   // ==========================================================
   // state: reset, run, power down
   wire int_reset = sw_reset_req | wdt_reset_req;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= RBC_RESET;
      end else if (filt_reset_reg || int_reset) begin
         state_reg <= RBC_RESET;
      end else begin
         case (state_reg)
            RBC_RESET: state_reg <= RBC_RUN;
            RBC_RUN: if (power_down_instruction && !nmi_sync_reg[1]) begin
               state_reg <= RBC_POWER_DOWN;
            end
            RBC_POWER_DOWN: if (wake_req) begin
               state_reg <= RBC_RUN; // only a reset or wake ends power down
            end
            default: state_reg <= RBC_RESET;
         endcase
      end
   end

   // reset exit: the single cycle in which the core leaves reset
   sequence s_reset_exit;
      state_reg == RBC_RESET && !filt_reset_reg && !int_reset;
   endsequence
   // power down asked for while the interrupt pin is still high
   sequence s_pd_refused;
      state_reg == RBC_RUN && power_down_instruction && nmi_sync_reg[1];
   endsequence
   chk_reset_trap: assert property (@(posedge clock) disable iff (!reset_n)
      s_reset_exit |=> trap_req && trap_number == RESET_TRAP_NUM
         && trap_vector == RESET_VECTOR)
      else $error("reset exit without trap zero");

   // ==========================================================
   // outputs from reset and power state
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cpu_reset <= 1'b1;
         clock_stop <= 1'b0;
      end else begin
         cpu_reset <= filt_reset_reg | int_reset;
         clock_stop <= (state_reg == RBC_RUN) && power_down_instruction
            && !nmi_sync_reg[1] && !filt_reset_reg && !int_reset;
         if (state_reg == RBC_POWER_DOWN && !wake_req && !filt_reset_reg && !int_reset) begin
            clock_stop <= 1'b1;
         end
      end
   end

   // a refused power down must leave the clocks running
   chk_pd_refused: assert property (@(posedge clock) disable iff (!reset_n)
      s_pd_refused |=> !clock_stop)
      else $error("power down taken with interrupt input high");
   chk_pd_hold: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg == RBC_POWER_DOWN && !wake_req && !filt_reset_reg && !int_reset |=> clock_stop)
      else $error("clocks running in power down");

   // ==========================================================
   // reset indication; async set by reset_n, sync set by filtered reset and, with rstind_on_internal, by internal reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reset_indication_output <= 1'b1;
      end else if (filt_reset_reg || (int_reset && rstind_on_internal)) begin
         reset_indication_output <= 1'b1;
      end else if (end_of_init_instruction || sw_rstind_release
                   || (rstind_release_at_end && state_reg == RBC_RESET && !int_reset)) begin
         reset_indication_output <= 1'b0;
      end
   end

   // software release is honoured whenever no reset is being raised
   chk_sw_release: assert property (@(posedge clock) disable iff (!reset_n)
      sw_rstind_release && !filt_reset_reg && !int_reset |=> !reset_indication_output)
      else $error("software release of reset indication ignored");

   // ==========================================================
   // boot configuration latch at the end of reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         boot_config <= '0;
         fetch_external <= 1'b0;
      end else if (state_reg == RBC_RESET && !filt_reset_reg && !int_reset) begin
         if (!external_access_select) begin
            boot_config <= {2'b00, read_strobe_in, low_config_port};
            fetch_external <= 1'b1;
         end else begin
            boot_config <= {{CFG_WIDTH{1'b0}}, read_strobe_in, addr_latch_strobe_in,
                            write_strobe_in};
            fetch_external <= 1'b0;
         end
      end
   end

   // ==========================================================
   // debug activation on falling edge of filtered reset (its release)
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filt_prev_reg <= 1'b1;
         debug_active <= 1'b0;
      end else begin
         filt_prev_reg <= filt_reset_reg;
         if (filt_prev_reg && !filt_reset_reg && dbg_sync_reg[1]) begin
            debug_active <= 1'b1;
         end else if (!dbg_sync_reg[1]) begin
            debug_active <= 1'b0; // debug reset low clears it
         end
      end
   end

   // ==========================================================
   // trap request: nmi falling edge, or reset vector on reset exit
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         nmi_prev_reg <= 1'b1;
         trap_req <= 1'b0;
         trap_vector <= RESET_VECTOR;
         trap_number <= RESET_TRAP_NUM;
      end else begin
         nmi_prev_reg <= nmi_sync_reg[1];
         trap_req <= 1'b0;
         if (state_reg == RBC_RESET && !filt_reset_reg && !int_reset) begin
            trap_req <= 1'b1;
            trap_vector <= RESET_VECTOR;
            trap_number <= RESET_TRAP_NUM;
         end else if (state_reg == RBC_RUN && nmi_prev_reg && !nmi_sync_reg[1]) begin
            trap_req <= 1'b1;
            trap_vector <= NMI_VECTOR;
            trap_number <= NMI_TRAP_NUM;
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_nmi_fall;
      state_reg == RBC_RUN && nmi_prev_reg && !nmi_sync_reg[1] && !filt_reset_reg && !int_reset;
   endsequence
   chk_nmi_trap_vec: assert property (@(posedge clock) disable iff (!reset_n)
      s_nmi_fall |=> trap_req && trap_number == NMI_TRAP_NUM && trap_vector == NMI_VECTOR)
      else $error("nmi edge without trap two");
   chk_filter_len: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(filt_reset_reg) |-> !$past(rst_sync_reg[1], FILT_CYCLES))
      else $error("reset passed filter too early");
   chk_pd_gate: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(clock_stop) |-> !$past(nmi_sync_reg[1]))
      else $error("power down with interrupt input high");
   chk_reset_ind: assert property (@(posedge clock) disable iff (!reset_n)
      filt_reset_reg |=> reset_indication_output)
      else $error("reset indication not set");
   chk_cpu_reset: assert property (@(posedge clock) disable iff (!reset_n)
      filt_reset_reg |=> cpu_reset)
      else $error("cpu not held in reset");
   chk_ext_boot: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(trap_req) && trap_number == RESET_TRAP_NUM
         |-> fetch_external == !$past(external_access_select))
      else $error("fetch source mismatch");
   chk_dbg_act: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(filt_reset_reg) && dbg_sync_reg[1] |=> debug_active)
      else $error("debug not activated");
   chk_eoi_release: assert property (@(posedge clock) disable iff (!reset_n)
      end_of_init_instruction && !filt_reset_reg && !int_reset |=> !reset_indication_output)
      else $error("reset indication not released");
endmodule
`default_nettype wire

// file: inc/rbc_pkg.sv
`default_nettype none
package rbc_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int FILT_PASS_NS = 100;
   // least time rounds up, at least one cycle
   localparam int FILT_CYCLES = (FILT_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 3;
   // ==========================================================
   // trap vectors and numbers
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [6:0] RESET_TRAP_NUM = 7'h00;
   localparam logic [15:0] NMI_VECTOR = 16'h0008;
   localparam logic [6:0] NMI_TRAP_NUM = 7'h02;
   localparam int CFG_W = 8;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   typedef enum {RBC_RESET, RBC_RUN, RBC_POWER_DOWN} rbc_state_t;
endpackage
`default_nettype wire

// file: bench/rbc_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// far side: reset circuit, debugger and nmi source
module rbc_far_side (
   input wire logic clock,
   output logic ext_reset_input,
   output logic nmi_in_n,
   output logic debug_reset_in
);
   // idle levels, so unused functions stay quiet
   initial begin
      ext_reset_input = 1'h1;
      nmi_in_n = 1'h1;
      debug_reset_in = 1'h0;
   end
   // lo of 4 or more covers 100 ns plus 2 clocks; 1 is a glitch
   task automatic hw_reset(input int lo, input logic dbg);
      debug_reset_in <= dbg;
      ext_reset_input <= 1'h0;
      repeat (lo) @(posedge clock);
      ext_reset_input <= 1'h1;
   endtask
   // a single low drive resets the debug system
   task automatic dbg_clear();
      debug_reset_in <= 1'h0;
   endtask
   task automatic set_nmi(input logic v);
      nmi_in_n <= v;
   endtask
endmodule
`default_nettype wire

// file: bench/reset_boot_config_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module reset_boot_config_control_test;
   import rbc_pkg::*;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic ers, nmi, dbg, eas = 1'h0, rd = 1'h0, ale = 1'h0, wr = 1'h0;
   logic [CFG_W-1:0] port = 8'h00;
   logic swr = 1'h0, wdr = 1'h0, on_int = 1'h0, at_end = 1'h0;
   logic eoi = 1'h0, swrel = 1'h0, pdi = 1'h0, wake = 1'h0;
   logic cpu_reset, ind, trap_req, dbg_act, fext, cstop;
   logic [15:0] tvec;
   logic [6:0] tnum;
   logic [CFG_W+2:0] bcfg;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0000C247;
   logic [34:0] notes[$];
   always #25 clock = ~clock;
   rbc_far_side far (.clock(clock), .ext_reset_input(ers), .nmi_in_n(nmi),
      .debug_reset_in(dbg));
   rbc_top dut (.clock(clock), .reset_n(reset_n), .ext_reset_input(ers), .nmi_in_n(nmi),
      .debug_reset_in(dbg), .external_access_select(eas), .low_config_port(port),
      .read_strobe_in(rd), .addr_latch_strobe_in(ale), .write_strobe_in(wr),
      .sw_reset_req(swr), .wdt_reset_req(wdr), .rstind_on_internal(on_int),
      .rstind_release_at_end(at_end), .end_of_init_instruction(eoi),
      .sw_rstind_release(swrel), .power_down_instruction(pdi), .wake_req(wake),
      .cpu_reset(cpu_reset), .reset_indication_output(ind), .trap_req(trap_req),
      .trap_vector(tvec), .trap_number(tnum), .debug_active(dbg_act),
      .fetch_external(fext), .boot_config(bcfg), .clock_stop(cstop));
   // ====
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // expected fetch source and latched straps for the current pins
   function automatic logic [11:0] ecfg();
      return eas ? {1'h0, 8'h00, rd, ale, wr} : {1'h1, 2'h0, rd, port};
   endfunction
   task automatic cmp_trap(input logic [34:0] g, input logic [34:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_lvl(input logic g, input logic e);
      cmp_trap({34'h0, g}, {34'h0, e});
   endtask
   task automatic note_rst();
      notes.push_back({RESET_VECTOR, RESET_TRAP_NUM, ecfg()});
   endtask
   // bounded wait: a lost trap must not hang the run
   task automatic wait_trap();
      for (int i = 0; i < 40 && notes.size() > 0; i++) @(posedge clock);
      if (notes.size() > 0) cmp_lvl(1'h1, 1'h0);
      notes.delete();
   endtask
   task automatic test_done();
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // each trap pulse takes the oldest note; an unnoted trap compares against x
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         fail_count++;
         test_done();
      end else if (reset_n === 1'h1 && trap_req !== 1'h0) begin
         if (notes.size() == 0) notes.push_back('x);
         cmp_trap({tvec, tnum, fext, bcfg}, notes.pop_front());
      end
   end
   // ====
   // main sequence
   initial begin
      note_rst();
      repeat (16) @(posedge clock);
      reset_n <= 1'h1;
      wait_trap();
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         {port, rd, ale, wr} <= seed[10:0];
         eas <= i[0];
         at_end <= i[0];
         @(posedge clock);
         note_rst();
         far.hw_reset(6, i[0]);
         cmp_lvl(cpu_reset, 1'h1);
         cmp_lvl(ind, 1'h1);
         wait_trap();
         repeat (2) @(posedge clock);
         cmp_lvl(ind, !i[0]);
         cmp_lvl(dbg_act, i[0]);
         far.dbg_clear();
         eoi <= 1'h1;
         @(posedge clock);
         eoi <= 1'h0;
         repeat (4) @(posedge clock);
         cmp_lvl(ind, 1'h0);
         cmp_lvl(dbg_act, 1'h0);
      end
      far.hw_reset(1, 1'h0);
      repeat (8) @(posedge clock);
      cmp_lvl(cpu_reset, 1'h0);
      // software then watchdog reset, indication option on then off
      for (int k = 0; k < 2; k++) begin
         on_int <= !k[0];
         at_end <= 1'h0; // keep the indication up until software releases it
         swr <= !k[0];
         wdr <= k[0];
         @(posedge clock);
         note_rst();
         swr <= 1'h0;
         wdr <= 1'h0;
         wait_trap();
         cmp_lvl(ind, !k[0]);
         swrel <= 1'h1;
         @(posedge clock);
         swrel <= 1'h0;
         repeat (3) @(posedge clock);
         cmp_lvl(ind, 1'h0);
      end
      pdi <= 1'h1;
      @(posedge clock);
      pdi <= 1'h0;
      repeat (3) @(posedge clock);
      cmp_lvl(cstop, 1'h0);
      notes.push_back({NMI_VECTOR, NMI_TRAP_NUM, ecfg()});
      far.set_nmi(1'h0);
      wait_trap();
      pdi <= 1'h1;
      @(posedge clock);
      pdi <= 1'h0;
      repeat (2) @(posedge clock);
      cmp_lvl(cstop, 1'h1);
      wake <= 1'h1;
      @(posedge clock);
      wake <= 1'h0;
      repeat (2) @(posedge clock);
      cmp_lvl(cstop, 1'h0);
      far.set_nmi(1'h1);
      repeat (6) @(posedge clock);
      test_done();
   end
endmodule
`default_nettype wire
